// ### logic/ipsel_defs.svh
// Register map, field positions and reset values of the image port signal select block.
// Assumes a 32-bit Avalon-MM slave with byte addresses; each register sits in one word.
`ifndef IPSEL_DEFS_SVH
`define IPSEL_DEFS_SVH

// Register indices; the byte address is four times the index
`define IPSEL_IDX_SIGSEL 8'h84
`define IPSEL_IDX_FORMAT 8'h85
`define IPSEL_IDX_EXTLVL 8'h86
`define IPSEL_IDX_STATUS 8'h88
`define IPSEL_IDX_POLCTL 8'h8a

// Output signal select register fields
`define IPSEL_SIG_FLAGA_LO 6
`define IPSEL_SIG_FLAGB_LO 4
`define IPSEL_SIG_VERT_LO 2
`define IPSEL_SIG_HORIZ_LO 0

// Image port format fields
`define IPSEL_FMT_SWAP_LO 6
`define IPSEL_FMT_LIMIT 5

// Flag select extension and FIFO level fields
`define IPSEL_EXT_FLAGA_MSB 5
`define IPSEL_EXT_FLAGB_MSB 4
`define IPSEL_EXT_LEVEL_LO 0

// Status register fields
`define IPSEL_STA_LEVEL_LO 0
`define IPSEL_STA_FULL 4
`define IPSEL_STA_EMPTY 5
`define IPSEL_STA_OVFL 6

// Polarity control fields
`define IPSEL_POL_FIELD 0
`define IPSEL_POL_TASK 1

// Reset values
`define IPSEL_RST_SIGSEL 8'h00
`define IPSEL_RST_FORMAT 8'h00
`define IPSEL_RST_EXTLVL 8'h00
`define IPSEL_RST_POLCTL 8'h00

// Video code limits
`define IPSEL_WIDE_MIN 8'h01
`define IPSEL_WIDE_MAX 8'hfe
`define IPSEL_NARROW_MIN 8'h08
`define IPSEL_NARROW_MAX 8'hf7

// Data FIFO shape
`define IPSEL_FIFO_DEPTH 8
`define IPSEL_FIFO_HALF 4'h4

`endif

// ### logic/ipsel_pkg.sv
// Types shared by the image port signal select block, its capture model and its bench.
// Assumes the constants of ipsel_defs.svh.
package ipsel_pkg;

    // Timing-related inputs from the scaler and event handler
    typedef struct packed {
        logic h_gate;
        logic in_href;
        logic in_window;
        logic v_gate;
        logic in_vref;
        logic field_id;
        logic task_a;
        logic sliced_frame;
    } ipsel_sync_t;

    // One output doubleword; timing marks the timing-code preamble
    typedef struct packed {
        logic timing;
        logic [31:0] data;
    } ipsel_word_t;

    // Sources selectable onto the general flag outputs
    typedef struct packed {
        logic aempty;
        logic afull;
        logic overflow;
        logic filled;
        logic low;
        logic sliced;
        logic task_flag;
        logic field_id;
    } ipsel_flags_t;

endpackage

// ### logic/ipsel_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a fill level output.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ipsel_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];
    assign level = count_q;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### logic/ipsel_top.sv
// Image port output signal selection, video range limiting and dword byte swap.
// Assumes synchronous inputs on the back-end clock and an Avalon-MM master.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`include "ipsel_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ipsel_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Scaler and event handler timing
    input wire ipsel_pkg::ipsel_sync_t sync_in,
    // Video dwords in
    input wire logic px_valid,
    output logic px_ready,
    input wire ipsel_pkg::ipsel_word_t px_word,
    // Video dwords out
    output logic out_valid,
    input wire logic out_ready,
    output ipsel_pkg::ipsel_word_t out_word,
    // Image port flags and references
    output logic general_flag_out_a,
    output logic general_flag_out_b,
    output logic horiz_reference_out,
    output logic vert_reference_out
);

    function automatic logic pick_flag(input logic [2:0] sel, input ipsel_pkg::ipsel_flags_t f);
        logic [7:0] v;
        v = f;
        return v[sel];
    endfunction

    function automatic logic [7:0] clip(input logic [7:0] b, input logic narrow);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = narrow ? `IPSEL_NARROW_MIN : `IPSEL_WIDE_MIN;
        hi = narrow ? `IPSEL_NARROW_MAX : `IPSEL_WIDE_MAX;
        if (b < lo) begin
            return lo;
        end else if (b > hi) begin
            return hi;
        end
        return b;
    endfunction

    function automatic logic [31:0] swap(input logic [31:0] w, input logic [1:0] mode);
        logic [31:0] r;
        r = w;
        unique case (mode)
            2'b00: r = w;
            2'b01: r = {w[23:16], w[31:24], w[7:0], w[15:8]};
            2'b10: r = {w[15:0], w[31:16]};
            2'b11: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
        endcase
        return r;
    endfunction

    function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // Registers
    logic [7:0] sigsel_q;
    logic [7:0] format_q;
    logic [7:0] extlvl_q;
    logic [7:0] polctl_q;
    logic ovfl_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [3:0] level;
    logic wr_take;
    logic ovfl_clr;

    // One wait cycle: the access completes on the second edge of the request
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = rdata_q;
    assign wr_take = avs_write && ack_q && avs_byteenable[0];
    assign ovfl_clr = wr_take && hit(avs_address, `IPSEL_IDX_STATUS)
                      && avs_writedata[`IPSEL_STA_OVFL];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sigsel_q <= `IPSEL_RST_SIGSEL;
            format_q <= `IPSEL_RST_FORMAT;
            extlvl_q <= `IPSEL_RST_EXTLVL;
            polctl_q <= `IPSEL_RST_POLCTL;
        end else if (wr_take) begin
            if (hit(avs_address, `IPSEL_IDX_SIGSEL)) begin
                sigsel_q <= avs_writedata[7:0];
            end
            if (hit(avs_address, `IPSEL_IDX_FORMAT)) begin
                format_q <= avs_writedata[7:0];
            end
            if (hit(avs_address, `IPSEL_IDX_EXTLVL)) begin
                extlvl_q <= avs_writedata[7:0];
            end
            if (hit(avs_address, `IPSEL_IDX_POLCTL)) begin
                polctl_q <= {6'h00, avs_writedata[1:0]};
            end
        end
    end

    // Read data is loaded at the first edge so it stands when waitrequest drops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            rdata_q <= 32'h0000_0000;
            if (hit(avs_address, `IPSEL_IDX_SIGSEL)) begin
                rdata_q[7:0] <= sigsel_q;
            end else if (hit(avs_address, `IPSEL_IDX_FORMAT)) begin
                rdata_q[7:0] <= format_q;
            end else if (hit(avs_address, `IPSEL_IDX_EXTLVL)) begin
                rdata_q[7:0] <= extlvl_q;
            end else if (hit(avs_address, `IPSEL_IDX_POLCTL)) begin
                rdata_q[7:0] <= polctl_q;
            end else if (hit(avs_address, `IPSEL_IDX_STATUS)) begin
                rdata_q[`IPSEL_STA_LEVEL_LO +: 4] <= level;
                rdata_q[`IPSEL_STA_FULL] <= (level == 4'(`IPSEL_FIFO_DEPTH));
                rdata_q[`IPSEL_STA_EMPTY] <= (level == 4'h0);
                rdata_q[`IPSEL_STA_OVFL] <= ovfl_q;
            end
        end
    end

    // Data path: limit codes, swap bytes, then buffer
    ipsel_pkg::ipsel_word_t fifo_in;
    logic [31:0] limited;
    logic [1:0] swap_mode;
    logic narrow;

    assign swap_mode = format_q[`IPSEL_FMT_SWAP_LO +: 2];
    assign narrow = format_q[`IPSEL_FMT_LIMIT];

    always_comb begin
        limited = px_word.data;
        // Preamble bytes carry timing codes and must not be limited
        if (!px_word.timing) begin
            for (int i = 0; i < 4; i++) begin
                limited[i*8 +: 8] = clip(px_word.data[i*8 +: 8], narrow);
            end
        end
        fifo_in.timing = px_word.timing;
        fifo_in.data = swap(limited, swap_mode);
    end

    ipsel_fifo #(
        .WIDTH($bits(ipsel_pkg::ipsel_word_t)),
        .DEPTH(`IPSEL_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .in_valid(px_valid),
        .in_ready(px_ready),
        .in_data(fifo_in),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_word),
        .level(level)
    );

    // A word offered while full would overflow an unstalled source
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ovfl_q <= 1'b0;
        end else if (px_valid && !px_ready) begin
            ovfl_q <= 1'b1;
        end else if (ovfl_clr) begin
            ovfl_q <= 1'b0;
        end
    end

    // Flag selection
    ipsel_pkg::ipsel_flags_t flags;
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    logic [3:0] thr;

    assign thr = extlvl_q[`IPSEL_EXT_LEVEL_LO +: 4];
    assign sel_a = {extlvl_q[`IPSEL_EXT_FLAGA_MSB], sigsel_q[`IPSEL_SIG_FLAGA_LO +: 2]};
    assign sel_b = {extlvl_q[`IPSEL_EXT_FLAGB_MSB], sigsel_q[`IPSEL_SIG_FLAGB_LO +: 2]};

    always_comb begin
        flags.field_id = sync_in.field_id ^ polctl_q[`IPSEL_POL_FIELD];
        flags.task_flag = sync_in.task_a ^ polctl_q[`IPSEL_POL_TASK];
        flags.sliced = sync_in.sliced_frame;
        flags.low = 1'b0;
        flags.filled = (level >= `IPSEL_FIFO_HALF);
        flags.overflow = ovfl_q;
        flags.afull = (level >= thr);
        flags.aempty = (level <= thr);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            general_flag_out_a <= 1'b0;
            general_flag_out_b <= 1'b0;
        end else begin
            general_flag_out_a <= pick_flag(sel_a, flags);
            general_flag_out_b <= pick_flag(sel_b, flags);
        end
    end

    // Reference outputs
    logic h_ext;
    logic h_gate_p_q;
    logic h_ext_p_q;
    logic v_gate_p_q;
    logic v_ref_p_q;
    logic [1:0] h_sel;
    logic [1:0] v_sel;
    logic h_d;
    logic v_d;

    assign h_ext = sync_in.h_gate || (sync_in.in_href && !sync_in.in_window);
    assign h_sel = sigsel_q[`IPSEL_SIG_HORIZ_LO +: 2];
    assign v_sel = sigsel_q[`IPSEL_SIG_VERT_LO +: 2];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            h_gate_p_q <= 1'b0;
            h_ext_p_q <= 1'b0;
            v_gate_p_q <= 1'b0;
            v_ref_p_q <= 1'b0;
        end else begin
            h_gate_p_q <= sync_in.h_gate;
            h_ext_p_q <= h_ext;
            v_gate_p_q <= sync_in.v_gate;
            v_ref_p_q <= sync_in.in_vref;
        end
    end

    always_comb begin
        unique case (h_sel)
            2'b00: h_d = sync_in.h_gate;
            2'b01: h_d = h_ext;
            2'b10: h_d = sync_in.h_gate && !h_gate_p_q;
            2'b11: h_d = h_ext && !h_ext_p_q;
        endcase
        unique case (v_sel)
            2'b00: v_d = sync_in.v_gate;
            2'b01: v_d = sync_in.in_vref;
            2'b10: v_d = sync_in.v_gate && !v_gate_p_q;
            2'b11: v_d = sync_in.in_vref && !v_ref_p_q;
        endcase
    end

    // Registering avoids glitches when software changes a selector mid-line
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            horiz_reference_out <= 1'b0;
            vert_reference_out <= 1'b0;
        end else begin
            horiz_reference_out <= h_d;
            vert_reference_out <= v_d;
        end
    end

    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    flag_a_field_a: assert property (
        $past(sel_a) == 3'b000 |->
        general_flag_out_a == ($past(sync_in.field_id) ^ $past(polctl_q[`IPSEL_POL_FIELD])))
        else $error("flag a does not follow field id");

    flag_a_task_a: assert property (
        $past(sel_a) == 3'b001 && $past(polctl_q[`IPSEL_POL_TASK]) == 1'b0 |->
        general_flag_out_a == $past(sync_in.task_a))
        else $error("flag a does not show task a high");

    flag_a_low_a: assert property (
        sel_a == 3'b011 [*2] |-> !general_flag_out_a)
        else $error("flag a not low under constant low code");

    // The sticky bit is set one edge after the refused offer, the output one edge later
    flag_a_ovfl_a: assert property (
        $past(sel_a) == 3'b101 && $past(px_valid && !px_ready, 2) |-> general_flag_out_a)
        else $error("flag a misses overflow");

    flag_b_empty_a: assert property (
        $past(sel_b) == 3'b111 && $past(level) == 4'h0 |-> general_flag_out_b)
        else $error("flag b misses almost empty");

    flag_a_full_a: assert property (
        $past(sel_a) == 3'b110 && $past(level) < $past(thr) |-> !general_flag_out_a)
        else $error("flag a almost full below level");

    horiz_pulse_a: assert property (
        h_sel == 2'b10 [*3] ##0 horiz_reference_out |-> !$past(horiz_reference_out))
        else $error("horizontal trigger longer than one cycle");

    horiz_gate_a: assert property (
        $past(h_sel) == 2'b00 |-> horiz_reference_out == $past(sync_in.h_gate))
        else $error("horizontal gate mismatch");

    vert_ref_a: assert property (
        $past(v_sel) == 2'b01 |-> vert_reference_out == $past(sync_in.in_vref))
        else $error("vertical output does not carry input reference");

    vert_pulse_a: assert property (
        v_sel == 2'b11 [*2] ##0 $rose(sync_in.in_vref) |=> vert_reference_out ##1
        (v_sel != 2'b11 || !vert_reference_out))
        else $error("vertical trigger from reference wrong");

    range_lim_a: assert property (
        px_valid && px_ready && !px_word.timing && narrow && swap_mode == 2'b00 |->
        fifo_in.data[7:0] >= `IPSEL_NARROW_MIN && fifo_in.data[7:0] <= `IPSEL_NARROW_MAX)
        else $error("video code outside narrow range");

    swap_full_a: assert property (
        px_word.timing && swap_mode == 2'b11 |->
        fifo_in.data == {px_word.data[7:0], px_word.data[15:8],
                         px_word.data[23:16], px_word.data[31:24]})
        else $error("byte reversal wrong");

    bus_wait_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");

    fifo_fill_c: cover property (!px_ready ##[1:20] px_ready);
    horiz_pulse_c: cover property (h_sel == 2'b11 ##0 horiz_reference_out);
    flag_sliced_c: cover property (sel_b == 3'b010 ##1 general_flag_out_b);
    status_clear_c: cover property (ovfl_q ##1 ovfl_clr ##1 !ovfl_q);
endmodule
`default_nettype wire

// ### verification/ipsel_capture_model.sv
// Capture port of the graphics controller on the output word stream.
// Assumes the bench asks for back-pressure through stall.
`timescale 1ns/1ps
`default_nettype none
module ipsel_capture_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Back-pressure request from the bench
    input wire logic stall,
    // Word stream from the block
    input wire logic out_valid,
    output logic out_ready,
    input wire ipsel_pkg::ipsel_word_t out_word
);
    ipsel_pkg::ipsel_word_t got[$];
    // Ready is registered, so a stall takes effect one cycle late, like a real port
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall;
            if (out_valid && out_ready) begin
                got.push_back(out_word);
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/test_image_port_aux_signal_select.sv
// Self-checking bench for the image port signal select block.
// Assumes the capture model on the output stream and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_image_port_aux_signal_select;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    ipsel_pkg::ipsel_sync_t sync_in = '0;
    logic px_valid = 1'b0;
    logic px_ready;
    ipsel_pkg::ipsel_word_t px_word = '0;
    logic out_valid;
    logic out_ready;
    logic stall = 1'b0;
    ipsel_pkg::ipsel_word_t out_word;
    logic fa, fb, hr, vr;
    logic [3:0] outs;
    logic [31:0] rd;
    logic [32:0] exp_q[$];
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;

    assign outs = {fa, fb, hr, vr};

    ipsel_top u_dut (
        .clock(clock), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sync_in(sync_in), .px_valid(px_valid), .px_ready(px_ready), .px_word(px_word),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
        .general_flag_out_a(fa), .general_flag_out_b(fb),
        .horiz_reference_out(hr), .vert_reference_out(vr)
    );

    ipsel_capture_model u_cap (
        .clock(clock), .rstn(rstn), .stall(stall),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word)
    );

    always #2.5 clock = ~clock;

    // Whole run needs well under a thousand cycles; the ceiling leaves ample margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("MISMATCH timeout expected finish seen hang");
            final_report();
        end
    end

    task final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low at an edge
    task bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        // Only the bench timeout ends a wait that never sees waitrequest low
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task wr8(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task rdchk(input string nm, input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, {25'h0, e}, {1'b0, rd});
    endtask

    // Settle on s0, step to s1, then look at one output in the two following cycles
    task edge_seq(input logic [7:0] s0, input logic [7:0] s1, input int idx,
                  input logic [1:0] e, input string nm);
        @(posedge clock);
        sync_in <= s0;
        repeat (3) @(posedge clock);
        sync_in <= s1;
        @(posedge clock);
        #1 chk(nm, {32'h0, e[1]}, {32'h0, outs[idx]});
        @(posedge clock);
        #1 chk(nm, {32'h0, e[0]}, {32'h0, outs[idx]});
    endtask

    task push(input logic [32:0] w);
        @(posedge clock);
        px_valid <= 1'b1;
        px_word <= w;
        do @(posedge clock); while (px_ready !== 1'b1);
        px_valid <= 1'b0;
    endtask

    function automatic logic [32:0] proc(logic [32:0] w, logic [1:0] sw, logic lim);
        logic [7:0] b;
        logic [32:0] r;
        r = {w[32], 32'h0};
        for (int k = 0; k < 4; k++) begin
            b = w[8 * (k ^ sw) +: 8];
            if (!w[32] && b < (lim ? 8'h08 : 8'h01)) b = lim ? 8'h08 : 8'h01;
            if (!w[32] && b > (lim ? 8'hf7 : 8'hfe)) b = lim ? 8'hf7 : 8'hfe;
            r[8 * k +: 8] = b;
        end
        return r;
    endfunction

    task drain(input int n);
        int t;
        t = 0;
        while (u_cap.got.size() < n && t < 300) begin
            @(posedge clock);
            t++;
        end
        chk("word_count", n, u_cap.got.size());
        for (int i = 0; i < n && i < u_cap.got.size(); i++) begin
            chk("out_word", exp_q[i], u_cap.got[i]);
        end
        exp_q.delete();
        u_cap.got.delete();
    endtask

    task test_regs;
        rdchk("sigsel_reset", 10'h210, 8'h00);
        rdchk("format_reset", 10'h214, 8'h00);
        rdchk("extlvl_reset", 10'h218, 8'h00);
        rdchk("polctl_reset", 10'h228, 8'h00);
        rdchk("status_reset", 10'h220, 8'h20);
        wr8(10'h210, 8'ha5);
        rdchk("sigsel_rw", 10'h210, 8'ha5);
        wr8(10'h3fc, 8'h5a);
        rdchk("unmapped", 10'h3fc, 8'h00);
        wr8(10'h210, 8'h00);
        $display("test_regs finished");
    endtask

    // Empty FIFO, level 0: almost full and almost empty both true
    task test_flags;
        logic [2:0] c;
        logic [7:0] p1 = 8'hc1;
        logic [7:0] p2 = 8'hc6;
        wr8(10'h218, 8'h00);
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 8; i++) begin
                c = i[2:0];
                wr8(10'h210, (f == 0) ? {c[1:0], 6'h0} : {2'h0, c[1:0], 4'h0});
                wr8(10'h218, (f == 0) ? {2'h0, c[2], 5'h0} : {3'h0, c[2], 4'h0});
                edge_seq(8'h04, 8'h04, 3 - f, {2{p1[i]}}, "flag_p1");
                edge_seq(8'h03, 8'h03, 3 - f, {2{p2[i]}}, "flag_p2");
            end
        end
        wr8(10'h218, 8'h00);
        $display("test_flags finished");
    endtask

    task test_refs;
        wr8(10'h210, 8'h00);
        edge_seq(8'h00, 8'h80, 1, 2'b11, "h_gate");
        edge_seq(8'h00, 8'h40, 1, 2'b00, "h_gate_href");
        edge_seq(8'h00, 8'h10, 0, 2'b11, "v_gate");
        wr8(10'h210, 8'h05);
        edge_seq(8'h00, 8'h40, 1, 2'b11, "h_ext_out");
        edge_seq(8'h00, 8'h60, 1, 2'b00, "h_ext_in");
        edge_seq(8'h00, 8'h08, 0, 2'b11, "v_ref");
        edge_seq(8'h00, 8'h10, 0, 2'b00, "v_ref_gate");
        wr8(10'h210, 8'h0a);
        edge_seq(8'h00, 8'h80, 1, 2'b10, "h_pulse");
        edge_seq(8'h00, 8'h40, 1, 2'b00, "h_pulse_href");
        edge_seq(8'h00, 8'h10, 0, 2'b10, "v_pulse");
        wr8(10'h210, 8'h0f);
        edge_seq(8'h00, 8'h40, 1, 2'b10, "h_ext_pulse");
        edge_seq(8'h00, 8'h08, 0, 2'b10, "v_ref_pulse");
        edge_seq(8'h00, 8'h10, 0, 2'b00, "v_ref_pulse_gate");
        $display("test_refs finished");
    endtask

    task test_stream;
        logic [32:0] w[3];
        w = '{33'h1_800000ff, 33'h0_00ff05f9, 33'h0_08f701fe};
        for (int s = 0; s < 4; s++) begin
            wr8(10'h214, {s[1:0], s[0], 5'h0});
            for (int i = 0; i < 3; i++) begin
                push(w[i]);
                exp_q.push_back(proc(w[i], s[1:0], s[0]));
            end
            drain(3);
        end
        $display("test_stream finished");
    endtask

    // Fill against a stalled port: the ninth offer meets a full FIFO
    task test_fill;
        // Flag A shows overflow (101), flag B half filled (100)
        wr8(10'h214, 8'hc0);
        wr8(10'h210, 8'h40);
        wr8(10'h218, 8'h30);
        stall <= 1'b1;
        fork
            for (int i = 0; i < 9; i++) begin
                push({1'b0, 8'h10, 8'h20, 8'h30, 8'h00 + 8'(i)});
                exp_q.push_back(proc({1'b0, 8'h10, 8'h20, 8'h30, 8'h00 + 8'(i)}, 2'h3, 1'b0));
            end
            begin
                for (int t = 0; t < 100 && px_ready !== 1'b0; t++) @(posedge clock);
                repeat (4) @(posedge clock);
                #1 chk("flag_a_overflow", 1, fa);
                chk("flag_b_filled", 1, fb);
                rdchk("status_full", 10'h220, 8'h58);
                @(posedge clock);
                stall <= 1'b0;
            end
        join
        drain(9);
        wr8(10'h220, 8'h40);
        rdchk("status_clear", 10'h220, 8'h20);
        $display("test_fill finished");
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        test_regs();
        test_flags();
        test_refs();
        test_stream();
        test_fill();
        final_report();
    end
endmodule
`default_nettype wire
